// *** core/itp_pkg.sv ***
// Shared constants and types of the serial target register port
package itp_pkg;

    // ------------------------------------------------------------
    // Addressing and register space
    // ------------------------------------------------------------
    localparam logic [6:0] ITP_DEF_ADDR   = 7'h41;  // Target address after power-up
    localparam logic [6:0] ITP_I3C_BCAST  = 7'h7E;  // Broadcast address of the newer bus
    localparam logic [7:0] ITP_ENABLE_LOC = 8'hE0;  // Only location reachable in standby
    localparam logic [7:0] ITP_PTR_RST    = 8'h00;  // Register pointer after reset
    localparam logic [7:0] ITP_BLOCK_DATA = 8'h00;  // Returned for unreachable reads
    localparam logic [7:0] ITP_PTR_STEP   = 8'h01;  // Pointer step per byte

    // ------------------------------------------------------------
    // Bit counting
    // ------------------------------------------------------------
    localparam logic [3:0] ITP_BYTE_BITS  = 4'h8;   // Bits in an address or data byte
    localparam logic [3:0] ITP_LAST_TX    = 4'h7;   // Index of last bit sent
    localparam logic [3:0] ITP_STEP_BIT   = 4'h1;

    // ------------------------------------------------------------
    // Bus speed grades and sampling
    // ------------------------------------------------------------
    localparam int ITP_STD_BPS     = 100000;
    localparam int ITP_FAST_BPS    = 400000;
    localparam int ITP_FMP_BPS     = 1000000;
    localparam int ITP_FMP_BIT_NS  = 1000;   // Bit time of the fastest grade
    localparam int ITP_LINK_CLK_NS = 125;    // Sampling clock period
    localparam int ITP_SYS_CLK_NS  = 20;     // System clock period
    localparam int ITP_MIN_SAMPLES = 8;      // Samples per bit the decoder needs

    // ------------------------------------------------------------
    // Link state machine
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,  // Not addressed
        ST_ADDR = 7'h02,  // Shifting in target address
        ST_AACK = 7'h04,  // Acknowledging address
        ST_RX   = 7'h08,  // Shifting in pointer or data
        ST_RACK = 7'h10,  // Answering a received byte
        ST_TX   = 7'h20,  // Shifting out read data
        ST_TACK = 7'h40   // Sampling host answer
    } itp_state_t;

    // Register access request crossing to the system side
    typedef struct packed {
        logic       wr;
        logic [7:0] loc;
        logic [7:0] data;
    } itp_req_t;

endpackage

// *** core/itp_hs_cdc.sv ***
// Toggle handshake that carries a word and its event between two clocks
`timescale 1ns/1ps
`default_nettype none

module itp_hs_cdc #(
    parameter int W = 8
) (
    // Source side
    input  wire logic         src_clk_i,
    input  wire logic         src_rst_n_i,
    input  wire logic         src_load_i,
    input  wire logic [W-1:0] src_data_i,
    // Destination side
    input  wire logic         dst_clk_i,
    input  wire logic         dst_rst_n_i,
    output logic              dst_pulse_o,
    output logic [W-1:0]      dst_data_o
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (W < 1) begin : g_bad_width
        $error("itp_hs_cdc: width must be at least one");
    end

    logic         tog_q;
    logic [W-1:0] hold_q;
    logic [2:0]   sync_q;
    logic         pulse_q;
    logic [W-1:0] data_q;
    wire          edge_seen = sync_q[2] ^ sync_q[1];

    // Source holds the word until the next load, so it is stable when sampled
    always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
        if (!src_rst_n_i) begin
            tog_q  <= 1'b0;
            hold_q <= '0;
        end else if (src_load_i) begin
            tog_q  <= ~tog_q;
            hold_q <= src_data_i;
        end
    end

    // First stage feeds only the second; edge taken between later stages
    always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
        if (!dst_rst_n_i) begin
            sync_q  <= 3'h0;
            pulse_q <= 1'b0;
            data_q  <= '0;
        end else begin
            sync_q  <= {sync_q[1:0], tog_q};
            pulse_q <= edge_seen;
            if (edge_seen) begin
                data_q <= hold_q;
            end
        end
    end

    assign dst_pulse_o = pulse_q;
    assign dst_data_o  = data_q;

endmodule

`default_nettype wire

// *** core/itp_target.sv ***
// Serial target port giving a host byte access to the register space
`timescale 1ns/1ps
`default_nettype none

module itp_target
    import itp_pkg::*;
#(
    parameter int LINK_CLK_NS = ITP_LINK_CLK_NS
) (
    // System clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RST_N_I,
    // Pin sampling clock
    input  wire logic       LINK_CLK_I,
    // Serial bus pins
    input  wire logic       SCL_I,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE_O,
    // Device control
    input  wire logic       STANDBY_I,
    input  wire logic       ADDR_LOAD_I,
    input  wire logic [6:0] ADDR_I,
    // Register space access
    output logic            REG_WR_O,
    output logic            REG_RD_O,
    output logic [7:0]      REG_ADDR_O,
    output logic [7:0]      REG_WDATA_O,
    input  wire logic [7:0] REG_RDATA_I
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    localparam int SAMPLES = ITP_FMP_BIT_NS / LINK_CLK_NS;

    if (SAMPLES < ITP_MIN_SAMPLES) begin : g_slow_link
        $error("itp_target: sampling clock too slow for the fastest grade");
    end

    // ------------------------------------------------------------
    // Reachability in standby
    // ------------------------------------------------------------
    function automatic logic loc_open(input logic [7:0] loc, input logic stby);
        loc_open = !stby || (loc == ITP_ENABLE_LOC);
    endfunction

    // ------------------------------------------------------------
    // Link side pin synchronisers
    // ------------------------------------------------------------
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic stby_s1;
    logic stby_s2;

    // Three flops on each bus pin, two on standby; only the second stage and later are decoded
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            scl_s1  <= 1'b1;
            scl_s2  <= 1'b1;
            scl_d   <= 1'b1;
            sda_s1  <= 1'b1;
            sda_s2  <= 1'b1;
            sda_d   <= 1'b1;
            stby_s1 <= 1'b0;
            stby_s2 <= 1'b0;
        end else begin
            scl_s1  <= SCL_I;
            scl_s2  <= scl_s1;
            scl_d   <= scl_s2;
            sda_s1  <= SDA_I;
            sda_s2  <= sda_s1;
            sda_d   <= sda_s2;
            stby_s1 <= STANDBY_I;
            stby_s2 <= stby_s1;
        end
    end

    // ------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------
    wire scl_rise = scl_s2 && !scl_d;
    wire scl_fall = !scl_s2 && scl_d;
    wire start_ev = scl_s2 && scl_d && sda_d && !sda_s2;
    wire stop_ev  = scl_s2 && scl_d && !sda_d && sda_s2;

    // ------------------------------------------------------------
    // Link state
    // ------------------------------------------------------------
    itp_state_t st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic [7:0] rdata_q;
    logic [6:0] tgt_q;
    logic       first_q;
    logic       mack_q;
    logic       sda_oe_q;
    logic       sda_out_q;

    logic       rsp_pulse;
    logic [7:0] rsp_data;
    logic       aset_pulse;
    logic [6:0] aset_data;
    logic       req_pulse;
    logic       wr_q;
    logic       rd_q;
    logic [7:0] loc_q;
    logic [7:0] wdat_q;

    // ------------------------------------------------------------
    // Decode of byte boundaries
    // ------------------------------------------------------------
    wire in_addr  = (st_q == ST_ADDR);
    wire in_rx    = (st_q == ST_RX);
    wire in_tx    = (st_q == ST_TX);
    wire shifting = in_addr || in_rx;
    wire byte_in  = scl_fall && (bit_q == ITP_BYTE_BITS);
    wire addr_end = in_addr && byte_in;
    // Legacy target only: broadcast address of the newer bus never matches
    wire addr_hit = addr_end && (sh_q[7:1] == tgt_q) && (tgt_q != ITP_I3C_BCAST);
    wire rx_byte  = in_rx && byte_in;
    wire ptr_byte = rx_byte && first_q;
    wire dat_byte = rx_byte && !first_q;
    wire tx_last  = in_tx && scl_fall && (bit_q == ITP_LAST_TX);
    wire ack_done = scl_fall && ((st_q == ST_AACK) || (st_q == ST_RACK));
    wire tack_end = (st_q == ST_TACK) && scl_fall;

    // ------------------------------------------------------------
    // Register requests
    // ------------------------------------------------------------
    // Prefetch at the end of each sent byte so data is ready after acknowledge
    wire [7:0] ptr_nxt = ptr_q + ITP_PTR_STEP;
    wire [7:0] rd_loc  = tx_last ? ptr_nxt : ptr_q;
    wire       rd_go   = (addr_hit && sh_q[0]) || tx_last;
    wire       rd_ok   = rd_go && loc_open(rd_loc, stby_s2);
    wire       wr_ok   = dat_byte && loc_open(ptr_q, stby_s2);
    wire       rd_blk  = rd_go && !rd_ok;
    wire       req_ld  = wr_ok || rd_ok;

    itp_req_t req_out;
    itp_req_t req_in;

    assign req_out.wr   = wr_ok;
    assign req_out.loc  = wr_ok ? ptr_q : rd_loc;
    assign req_out.data = sh_q;

    // ------------------------------------------------------------
    // State sequencing
    // ------------------------------------------------------------
    // Start and stop win over any bit activity in progress
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_q <= ST_IDLE;
        end else if (start_ev) begin
            st_q <= ST_ADDR;
        end else if (stop_ev) begin
            st_q <= ST_IDLE;
        end else if (addr_end) begin
            st_q <= addr_hit ? ST_AACK : ST_IDLE;
        end else if (rx_byte) begin
            st_q <= ST_RACK;
        end else if (ack_done) begin
            st_q <= (st_q == ST_AACK && sh_q[0]) ? ST_TX : ST_RX;
        end else if (tx_last) begin
            st_q <= ST_TACK;
        end else if (tack_end) begin
            st_q <= mack_q ? ST_TX : ST_IDLE;
        end
    end

    // Bit counter: rising edges while receiving, falling edges while sending
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bit_q <= 4'h0;
        end else if (start_ev || ack_done || tack_end) begin
            bit_q <= 4'h0;
        end else if ((shifting && scl_rise) || (in_tx && scl_fall)) begin
            bit_q <= bit_q + ITP_STEP_BIT;
        end
    end

    // Receive shifter and host answer sampling
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sh_q   <= 8'h00;
            mack_q <= 1'b0;
        end else if (shifting && scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s2};
        end else if ((st_q == ST_TACK) && scl_rise) begin
            mack_q <= !sda_s2;
        end
    end

    // First byte after a write address is the pointer
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            first_q <= 1'b0;
        end else if (addr_hit) begin
            first_q <= 1'b1;
        end else if (rx_byte) begin
            first_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register pointer
    // ------------------------------------------------------------
    // Stop does not touch it, so a later read resumes where the last ended
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ptr_q <= ITP_PTR_RST;
        end else if (ptr_byte) begin
            ptr_q <= sh_q;
        end else if (dat_byte || tx_last) begin
            ptr_q <= ptr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data and target address
    // ------------------------------------------------------------
    // Unreachable locations read as a constant without touching the space
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata_q <= 8'h00;
        end else if (rd_blk) begin
            rdata_q <= ITP_BLOCK_DATA;
        end else if (rsp_pulse) begin
            rdata_q <= rsp_data;
        end
    end

    // Default address until the system side loads a new one
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tgt_q <= ITP_DEF_ADDR;
        end else if (aset_pulse) begin
            tgt_q <= aset_data;
        end
    end

    // ------------------------------------------------------------
    // Data line driver
    // ------------------------------------------------------------
    wire tx_load = (ack_done && st_q == ST_AACK && sh_q[0]) || (tack_end && mack_q);

    // Open drain: enable pulls low; released on any start, stop or idle
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sda_oe_q  <= 1'b0;
            sda_out_q <= 1'b0;
            tx_q      <= 8'hFF;
        end else if (start_ev || stop_ev) begin
            sda_oe_q <= 1'b0;
        end else if (addr_end) begin
            sda_oe_q <= addr_hit;
        end else if (rx_byte) begin
            sda_oe_q <= first_q || wr_ok;
        end else if (tx_load) begin
            tx_q     <= rdata_q;
            sda_oe_q <= !rdata_q[7];
        end else if (tx_last || ack_done || tack_end) begin
            sda_oe_q <= 1'b0;
        end else if (in_tx && scl_fall) begin
            tx_q     <= {tx_q[6:0], 1'b1};
            sda_oe_q <= !tx_q[6];
        end
    end

    assign SDA_O    = sda_out_q;
    assign SDA_OE_O = sda_oe_q;

    // ------------------------------------------------------------
    // Clock domain crossings
    // ------------------------------------------------------------
    itp_hs_cdc #(.W($bits(itp_req_t))) u_req_cdc (
        .src_clk_i   (LINK_CLK_I),
        .src_rst_n_i (RST_N_I),
        .src_load_i  (req_ld),
        .src_data_i  (req_out),
        .dst_clk_i   (CLK_I),
        .dst_rst_n_i (RST_N_I),
        .dst_pulse_o (req_pulse),
        .dst_data_o  (req_in)
    );

    itp_hs_cdc #(.W(8)) u_rsp_cdc (
        .src_clk_i   (CLK_I),
        .src_rst_n_i (RST_N_I),
        .src_load_i  (rd_q),
        .src_data_i  (REG_RDATA_I),
        .dst_clk_i   (LINK_CLK_I),
        .dst_rst_n_i (RST_N_I),
        .dst_pulse_o (rsp_pulse),
        .dst_data_o  (rsp_data)
    );

    itp_hs_cdc #(.W(7)) u_addr_cdc (
        .src_clk_i   (CLK_I),
        .src_rst_n_i (RST_N_I),
        .src_load_i  (ADDR_LOAD_I),
        .src_data_i  (ADDR_I),
        .dst_clk_i   (LINK_CLK_I),
        .dst_rst_n_i (RST_N_I),
        .dst_pulse_o (aset_pulse),
        .dst_data_o  (aset_data)
    );

    // ------------------------------------------------------------
    // System side register strobes
    // ------------------------------------------------------------

    // One-cycle strobes; read data is taken on the edge ending the strobe
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            loc_q  <= 8'h00;
            wdat_q <= 8'h00;
        end else begin
            wr_q <= req_pulse && req_in.wr;
            rd_q <= req_pulse && !req_in.wr;
            if (req_pulse) begin
                loc_q  <= req_in.loc;
                wdat_q <= req_in.data;
            end
        end
    end

    assign REG_WR_O    = wr_q;
    assign REG_RD_O    = rd_q;
    assign REG_ADDR_O  = loc_q;
    assign REG_WDATA_O = wdat_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    addr_miss_a : assert property (
        @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        (addr_end && !start_ev && !stop_ev && sh_q[7:1] != tgt_q) |=> !sda_oe_q && st_q == ST_IDLE)
        else $error("answered a foreign address");

    addr_load_a : assert property (
        @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        aset_pulse |=> tgt_q == $past(aset_data))
        else $error("target address not reloaded");

    wr_step_a : assert property (
        @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        dat_byte |=> ptr_q == $past(ptr_q) + ITP_PTR_STEP)
        else $error("pointer did not step after write byte");

    rd_step_a : assert property (
        @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        (tx_last && !start_ev && !stop_ev) |=> ptr_q == $past(ptr_nxt) && st_q == ST_TACK && !sda_oe_q)
        else $error("pointer did not step after read byte");

    stop_keep_a : assert property (
        @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        stop_ev |=> ptr_q == $past(ptr_q) ##1 st_q == ST_IDLE || start_ev)
        else $error("pointer changed at stop");

    rd_start_a : assert property (
        @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        (addr_hit && sh_q[0] && !stby_s2) |-> req_ld && !req_out.wr && req_out.loc == ptr_q)
        else $error("read did not start at kept pointer");

    wr_ack_a : assert property (
        @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        (rx_byte && !start_ev && !stop_ev) |=> sda_oe_q == ($past(first_q) || $past(wr_ok)) && st_q == ST_RACK)
        else $error("wrong answer to received byte");

    nack_rel_a : assert property (
        @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        (tack_end && !mack_q && !start_ev && !stop_ev) |=> !sda_oe_q [*2])
        else $error("data line held after host refusal");

    idle_quiet_a : assert property (
        @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        (st_q == ST_IDLE && !addr_end) |=> !sda_oe_q)
        else $error("drove the bus while not addressed");

    stby_block_a : assert property (
        @(posedge LINK_CLK_I) disable iff (!RST_N_I)
        (dat_byte && stby_s2 && ptr_q != ITP_ENABLE_LOC) |-> !req_ld)
        else $error("blocked location reached in standby");

    sys_strobe_a : assert property (
        @(posedge CLK_I) disable iff (!RST_N_I)
        (REG_WR_O || REG_RD_O) |-> !(REG_WR_O && REG_RD_O) ##1 !REG_WR_O && !REG_RD_O)
        else $error("register strobe longer than one cycle");

endmodule

`default_nettype wire

// *** dv/itp_host_model.sv ***
// Behavioural host bus controller for the serial target port
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Host model
// ------------------------------------------------------------
module itp_host_model (
    // Bus pins
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    int q = 31; // Quarter bit in clk_i cycles; 14 keeps fast-plus below 1 Mbit/s
    initial begin
        scl_o = 1'h1;
        sda_pull_o = 1'h0;
    end
    // Bus clock stands high between frames
    task automatic tick();
        repeat (q) @(posedge clk_i);
    endtask
    // One bit; data moves only while scl is low
    task automatic bit_io(input logic b, output logic s);
        sda_pull_o <= !b;
        tick();
        scl_o <= 1'h1;
        tick();
        s = sda_i;
        tick();
        scl_o <= 1'h0;
        tick();
    endtask
    // Start or repeated start
    task automatic start_c();
        sda_pull_o <= 1'h0;
        tick();
        scl_o <= 1'h1;
        tick();
        sda_pull_o <= 1'h1;
        tick();
        scl_o <= 1'h0;
        tick();
    endtask
    // Stop closes every transfer, also after a refusal
    task automatic stop_c();
        sda_pull_o <= 1'h1;
        tick();
        scl_o <= 1'h1;
        tick();
        sda_pull_o <= 1'h0;
        tick();
        tick();
    endtask
    // MSB first, ninth slot left to the device
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'h1, s);
        ack = !s;
    endtask
    // Acknowledge all but the last byte
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench of the serial target port
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module testbench;
    import itp_pkg::*;
    logic       clk = 1'h0, lclk = 1'h0, rst_n = 1'h0, stby = 1'h0, ld = 1'h0;
    logic [6:0] ld_addr = 7'h00, na;
    logic [7:0] mem [256];
    logic [7:0] rdata, r_addr, r_wdata;
    logic       r_wr, r_rd, sda_o, sda_oe;
    wire logic  scl, pull, sda;
    logic [15:0] exp_q [$];
    int         failures = 0, checks = 0;
    int         rd_blk_n = 0;
    // Open drain wire with pull-up
    assign sda = !(pull || (sda_oe && !sda_o));
    assign rdata = mem[r_addr];
    initial forever #10 clk = ~clk;
    initial begin
        #37;
        forever #62.5 lclk = ~lclk;
    end
    itp_target uut (.CLK_I(clk), .RST_N_I(rst_n), .LINK_CLK_I(lclk), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE_O(sda_oe), .STANDBY_I(stby), .ADDR_LOAD_I(ld), .ADDR_I(ld_addr), .REG_WR_O(r_wr),
        .REG_RD_O(r_rd), .REG_ADDR_O(r_addr), .REG_WDATA_O(r_wdata), .REG_RDATA_I(rdata));
    itp_host_model h (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic ack;
        h.wr_byte(b, ack);
        check(ack, exp_ack);
    endtask
    // Writes n random bytes from pointer p; a blocked byte is refused
    task automatic wr_data(input logic [7:0] p, input int n, input logic ok);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (ok) exp_q.push_back({8'(p + i), d});
            send(d, ok);
        end
    endtask
    // Reads n bytes from p, the last one refused by the host
    task automatic rd_data(input logic [7:0] p, input int n, input logic blk);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            h.rd_byte(i == n - 1, d);
            check(d, blk ? ITP_BLOCK_DATA : mem[8'(p + i)]);
        end
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    // Each write strobe takes the oldest note; a strobe with none noted fails
    always @(posedge clk)
        if (r_wr === 1'h1) check({r_addr, r_wdata}, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX);
    // Read strobes in standby; blocked reads must never reach the space
    always @(posedge clk) if (stby && r_rd !== 1'h0) rd_blk_n++;
    // Hang guard
    initial begin
        repeat (95000) @(posedge clk);
        failures++;
        give_verdict();
    end
    initial begin
        void'($urandom(23992));
        for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
        na = 7'h20 | 7'($urandom % 16);
        // Long enough for three link clock edges
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        repeat (10) @(posedge clk);
        h.start_c();
        send({ITP_DEF_ADDR, 1'h0}, 1'h1);
        send(8'hFE, 1'h1);
        wr_data(8'hFE, 3, 1'h1);
        h.stop_c();
        note("write wrap");
        for (int g = 0; g < 2; g++) begin
            h.start_c();
            send({ITP_DEF_ADDR, 1'h0}, 1'h1);
            send(8'h10 + 8'(g * 8'h70), 1'h1);
            h.start_c();
            send({ITP_DEF_ADDR, 1'h1}, 1'h1);
            rd_data(8'h10 + 8'(g * 8'h70), 3, 1'h0);
            h.stop_c();
            h.start_c();
            send({ITP_DEF_ADDR, 1'h1}, 1'h1);
            rd_data(8'h13 + 8'(g * 8'h70), 2, 1'h0);
            h.stop_c();
            note("read and continue");
            h.q = 14;
        end
        for (int k = 0; k < 2; k++) begin
            h.start_c();
            send({k ? ITP_I3C_BCAST : (ITP_DEF_ADDR ^ 7'h01), 1'h0}, 1'h0);
            h.stop_c();
        end
        note("foreign address");
        @(posedge clk);
        ld <= 1'h1;
        ld_addr <= na;
        @(posedge clk);
        ld <= 1'h0;
        repeat (50) @(posedge clk);
        h.start_c();
        send({ITP_DEF_ADDR, 1'h0}, 1'h0);
        h.stop_c();
        h.start_c();
        send({na, 1'h0}, 1'h1);
        send(8'h50, 1'h1);
        wr_data(8'h50, 1, 1'h1);
        h.stop_c();
        note("new address");
        stby <= 1'h1;
        for (int k = 0; k < 2; k++) begin
            h.start_c();
            send({na, 1'h0}, 1'h1);
            send(k ? ITP_ENABLE_LOC : 8'h20, 1'h1);
            wr_data(k ? ITP_ENABLE_LOC : 8'h20, 1, k[0]);
            h.stop_c();
        end
        h.start_c();
        send({na, 1'h1}, 1'h1);
        rd_data(ITP_ENABLE_LOC + ITP_PTR_STEP, 1, 1'h1);
        h.stop_c();
        stby <= 1'h0;
        note("standby");
        repeat (100) @(posedge clk);
        check(16'(exp_q.size()), 16'h0000);
        check(16'(rd_blk_n), 16'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
